// *** bscu_map.svh ***
`ifndef BSCU_MAP_SVH
`define BSCU_MAP_SVH

// Datapath widths
`define BSCU_PC_W 16
`define BSCU_K_W 7
`define BSCU_BYTE_W 8
`define BSCU_IDX_W 3
`define BSCU_CYC_W 2
`define BSCU_OP_W 5

// Bit positions in the core flag register
`define BSCU_FLAG_C 3'h0
`define BSCU_FLAG_Z 3'h1
`define BSCU_FLAG_N 3'h2
`define BSCU_FLAG_V 3'h3
`define BSCU_FLAG_S 3'h4
`define BSCU_FLAG_H 3'h5
`define BSCU_FLAG_T 3'h6
`define BSCU_FLAG_I 3'h7

// Program counter steps, in words
`define BSCU_STEP_NEXT 16'h0001
`define BSCU_STEP_SKIP_ONE 16'h0002
`define BSCU_STEP_SKIP_TWO 16'h0003

// Cycle counts
`define BSCU_CYC_NOT_TAKEN 2'h1
`define BSCU_CYC_BRANCH 2'h2
`define BSCU_CYC_SKIP_ONE 2'h2
`define BSCU_CYC_SKIP_TWO 2'h3
`define BSCU_CYC_LAST 2'h1

// Reset values
`define BSCU_PC_RST 16'h0000
`define BSCU_CYC_RST 2'h0

`endif

// *** bscu_pkg.sv ***
`default_nettype none
`include "bscu_map.svh"

package bscu_pkg;

    typedef logic [`BSCU_PC_W-1:0] bscu_pc_t;
    typedef logic [`BSCU_CYC_W-1:0] bscu_cyc_t;
    typedef logic [`BSCU_BYTE_W-1:0] bscu_byte_t;

    typedef enum logic [`BSCU_OP_W-1:0] {
        op_none,
        op_skip_reg_bit_one,
        op_skip_io_bit_zero,
        op_skip_io_bit_one,
        op_branch_flag_index_one,
        op_branch_flag_index_zero,
        op_branch_equal,
        op_branch_not_equal,
        op_branch_carry_one,
        op_branch_carry_zero,
        op_branch_same_or_higher,
        op_branch_lower_unsigned,
        op_branch_negative,
        op_branch_positive,
        op_branch_signed_ge,
        op_branch_signed_lt,
        op_branch_half_carry_one,
        op_branch_half_carry_zero,
        op_branch_transfer_bit_one,
        op_branch_transfer_bit_zero,
        op_branch_overflow_one
    } bscu_op_e;

    typedef enum logic {
        st_idle,
        st_wait
    } bscu_state_e;

endpackage

`default_nettype wire

// *** bscu_branch_skip.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bscu_map.svh"

module bscu_branch_skip
    import bscu_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic req,
    input wire bscu_op_e op,
    input wire logic [`BSCU_IDX_W-1:0] bit_sel,
    input wire logic [`BSCU_K_W-1:0] offset,
    input wire bscu_pc_t pc,
    input wire logic next_two_word,
    input wire bscu_byte_t reg_data,
    input wire bscu_byte_t io_data,
    input wire bscu_byte_t flags,
    output logic busy_r,
    output logic done_r,
    output logic taken_r,
    output bscu_pc_t pc_next_r,
    output bscu_cyc_t cycles_r,
    output logic flag_write_r
);

    function automatic logic pick_bit(input bscu_byte_t value, input logic [`BSCU_IDX_W-1:0] idx);
        pick_bit = value[idx];
    endfunction

    function automatic bscu_pc_t sext_k(input logic [`BSCU_K_W-1:0] k);
        sext_k = {{(`BSCU_PC_W-`BSCU_K_W){k[`BSCU_K_W-1]}}, k};
    endfunction

    bscu_state_e state_r;
    bscu_state_e state_nxt;
    bscu_cyc_t wait_r;
    bscu_cyc_t wait_nxt;
    logic done_nxt;

    // Flags as seen in the request cycle
    wire logic flag_c;
    wire logic flag_z;
    wire logic flag_n;
    wire logic flag_v;
    wire logic flag_h;
    wire logic flag_t;
    wire logic flag_sel;
    wire logic signed_lt;

    assign flag_c = pick_bit(flags, `BSCU_FLAG_C);
    assign flag_z = pick_bit(flags, `BSCU_FLAG_Z);
    assign flag_n = pick_bit(flags, `BSCU_FLAG_N);
    assign flag_v = pick_bit(flags, `BSCU_FLAG_V);
    assign flag_h = pick_bit(flags, `BSCU_FLAG_H);
    assign flag_t = pick_bit(flags, `BSCU_FLAG_T);
    assign flag_sel = pick_bit(flags, bit_sel);
    // Computed from N and V directly, not from the stored sign flag
    assign signed_lt = flag_n ^ flag_v;

    // Tested operand bits for the skips
    wire logic reg_bit;
    wire logic io_bit;

    assign reg_bit = pick_bit(reg_data, bit_sel);
    assign io_bit = pick_bit(io_data, bit_sel);

    // Per-operation hit terms
    wire logic hit_skip_reg_one;
    wire logic hit_skip_io_zero;
    wire logic hit_skip_io_one;
    wire logic hit_flag_one;
    wire logic hit_flag_zero;
    wire logic hit_equal;
    wire logic hit_not_equal;
    wire logic hit_carry_one;
    wire logic hit_carry_zero;
    wire logic hit_same_higher;
    wire logic hit_lower;
    wire logic hit_negative;
    wire logic hit_positive;
    wire logic hit_signed_ge;
    wire logic hit_signed_lt;
    wire logic hit_half_one;
    wire logic hit_half_zero;
    wire logic hit_tbit_one;
    wire logic hit_tbit_zero;
    wire logic hit_overflow_one;

    assign hit_skip_reg_one = (op == op_skip_reg_bit_one) && reg_bit;
    assign hit_skip_io_zero = (op == op_skip_io_bit_zero) && !io_bit;
    assign hit_skip_io_one = (op == op_skip_io_bit_one) && io_bit;
    assign hit_flag_one = (op == op_branch_flag_index_one) && flag_sel;
    assign hit_flag_zero = (op == op_branch_flag_index_zero) && !flag_sel;
    assign hit_equal = (op == op_branch_equal) && flag_z;
    assign hit_not_equal = (op == op_branch_not_equal) && !flag_z;
    assign hit_carry_one = (op == op_branch_carry_one) && flag_c;
    assign hit_carry_zero = (op == op_branch_carry_zero) && !flag_c;
    assign hit_same_higher = (op == op_branch_same_or_higher) && !flag_c;
    assign hit_lower = (op == op_branch_lower_unsigned) && flag_c;
    assign hit_negative = (op == op_branch_negative) && flag_n;
    assign hit_positive = (op == op_branch_positive) && !flag_n;
    assign hit_signed_ge = (op == op_branch_signed_ge) && !signed_lt;
    assign hit_signed_lt = (op == op_branch_signed_lt) && signed_lt;
    assign hit_half_one = (op == op_branch_half_carry_one) && flag_h;
    assign hit_half_zero = (op == op_branch_half_carry_zero) && !flag_h;
    assign hit_tbit_one = (op == op_branch_transfer_bit_one) && flag_t;
    assign hit_tbit_zero = (op == op_branch_transfer_bit_zero) && !flag_t;
    assign hit_overflow_one = (op == op_branch_overflow_one) && flag_v;

    // Class of the requested operation
    wire logic is_skip;
    wire logic is_branch;
    wire logic op_legal;

    assign is_skip = (op == op_skip_reg_bit_one)
        || (op == op_skip_io_bit_zero)
        || (op == op_skip_io_bit_one);
    assign is_branch = (op >= op_branch_flag_index_one) && (op <= op_branch_overflow_one);
    // Codes past the last operation are ignored rather than guessed at
    assign op_legal = is_skip || is_branch;

    wire logic skip_hit;
    wire logic branch_hit;
    wire logic take;

    assign skip_hit = hit_skip_reg_one
        || hit_skip_io_zero
        || hit_skip_io_one;
    assign branch_hit = hit_flag_one
        || hit_flag_zero
        || hit_equal
        || hit_not_equal
        || hit_carry_one
        || hit_carry_zero
        || hit_same_higher
        || hit_lower
        || hit_negative
        || hit_positive
        || hit_signed_ge
        || hit_signed_lt
        || hit_half_one
        || hit_half_zero
        || hit_tbit_one
        || hit_tbit_zero
        || hit_overflow_one;
    assign take = skip_hit || branch_hit;

    // Target arithmetic wraps at the top of program space, as the core's PC does
    wire bscu_pc_t pc_step;
    wire bscu_pc_t branch_tgt;
    wire bscu_pc_t skip_tgt;
    wire bscu_pc_t target;

    assign pc_step = bscu_pc_t'(pc + `BSCU_STEP_NEXT);
    assign branch_tgt = bscu_pc_t'(pc_step + sext_k(offset));
    assign skip_tgt = next_two_word
        ? bscu_pc_t'(pc + `BSCU_STEP_SKIP_TWO)
        : bscu_pc_t'(pc + `BSCU_STEP_SKIP_ONE);
    assign target = !take ? pc_step
        : is_skip ? skip_tgt
        : branch_tgt;

    // Cycle count of the accepted instruction
    wire bscu_cyc_t skip_cyc;
    wire bscu_cyc_t cyc;

    assign skip_cyc = next_two_word ? `BSCU_CYC_SKIP_TWO : `BSCU_CYC_SKIP_ONE;
    assign cyc = !take ? `BSCU_CYC_NOT_TAKEN
        : is_skip ? skip_cyc
        : `BSCU_CYC_BRANCH;

    wire logic accept;
    wire logic multi;

    // Requests during a multi-cycle instruction are dropped; the core stalls on busy
    assign accept = req && (state_r == st_idle) && op_legal;
    assign multi = (cyc != `BSCU_CYC_NOT_TAKEN);

    always_comb begin
        state_nxt = state_r;
        wait_nxt = wait_r;
        done_nxt = 1'b0;
        unique case (state_r)
            st_idle: begin
                if (accept) begin
                    if (multi) begin
                        state_nxt = st_wait;
                        wait_nxt = bscu_cyc_t'(cyc - `BSCU_CYC_LAST);
                    end else begin
                        done_nxt = 1'b1;
                    end
                end
            end
            st_wait: begin
                if (wait_r == `BSCU_CYC_LAST) begin
                    state_nxt = st_idle;
                    wait_nxt = `BSCU_CYC_RST;
                    done_nxt = 1'b1;
                end else begin
                    wait_nxt = bscu_cyc_t'(wait_r - `BSCU_CYC_LAST);
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= st_idle;
            wait_r <= `BSCU_CYC_RST;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wait_r <= wait_nxt;
            busy_r <= (state_nxt == st_wait);
            done_r <= done_nxt;
        end
    end

    // Result is held from acceptance until the next accepted request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            taken_r <= 1'b0;
            pc_next_r <= `BSCU_PC_RST;
            cycles_r <= `BSCU_CYC_RST;
        end else if (accept) begin
            taken_r <= take;
            pc_next_r <= target;
            cycles_r <= cyc;
        end
    end

    // No skip or branch ever writes the flag register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag_write_r <= 1'b0;
        end else begin
            flag_write_r <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// *** bscu_branch_skip_end.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** bscu_branch_skip_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module bscu_branch_skip_chk
    import bscu_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic req,
    input wire bscu_op_e op,
    input wire logic [2:0] bit_sel,
    input wire logic [6:0] offset,
    input wire bscu_pc_t pc,
    input wire logic next_two_word,
    input wire bscu_byte_t reg_data,
    input wire bscu_byte_t io_data,
    input wire bscu_byte_t flags,
    input wire logic busy_r,
    input wire logic done_r,
    input wire logic taken_r,
    input wire bscu_pc_t pc_next_r,
    input wire bscu_cyc_t cycles_r,
    input wire logic flag_write_r
);
    wire is_br = op >= op_branch_flag_index_one && op <= op_branch_overflow_one;
    wire is_sk = op != op_none && op < op_branch_flag_index_one;
    wire acc = req && !busy_r && (is_br || is_sk);
    wire bscu_pc_t br_pc = pc + 16'h0001 + {{9{offset[6]}}, offset};
    wire bscu_pc_t sk_pc = pc + (next_two_word ? 16'h0003 : 16'h0002);
    wire bscu_pc_t inc_pc = pc + 16'h0001;
    wire nv_bit = flags[2] ^ flags[3];
    wire io_bit = io_data[bit_sel];
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    flags_untouched_a: assert property (flag_write_r == 1'b0) else $error("flag write seen");
    br_target_a: assert property (acc && is_br |=> pc_next_r == (taken_r ? $past(br_pc) : $past(inc_pc)))
        else $error("branch target wrong");
    sk_target_a: assert property (acc && is_sk |=> pc_next_r == (taken_r ? $past(sk_pc) : $past(inc_pc)))
        else $error("skip target wrong");
    untaken_one_a: assert property (acc ##1 !taken_r |-> cycles_r == 2'h1 && done_r && !busy_r)
        else $error("untaken timing wrong");
    br_two_a: assert property (acc && is_br ##1 taken_r |-> cycles_r == 2'h2 && busy_r ##1 done_r && !busy_r)
        else $error("taken branch timing wrong");
    sk_three_a: assert property (acc && is_sk && next_two_word ##1
        taken_r |-> cycles_r == 2'h3 ##0 (busy_r && !done_r)[*2] ##1 done_r) else $error("long skip timing wrong");
    reg_one_a: assert property (acc && op == op_skip_reg_bit_one |=> taken_r == $past(reg_data[bit_sel]))
        else $error("register bit decision wrong");
    flag_idx_a: assert property (acc && op == op_branch_flag_index_one |=> taken_r == $past(flags[bit_sel]))
        else $error("flag index decision wrong");
    eq_cond_a: assert property (acc && op == op_branch_equal |=> taken_r == $past(flags[1]))
        else $error("equal decision wrong");
    lt_cond_a: assert property (acc && op == op_branch_signed_lt |=> taken_r == $past(nv_bit))
        else $error("signed less decision wrong");
    io_zero_a: assert property (acc && op == op_skip_io_bit_zero |=> taken_r == !$past(io_bit))
        else $error("io zero decision wrong");
    busy_hold_a: assert property (busy_r |=> $stable(pc_next_r)) else $error("request taken while busy");
endmodule
bind bscu_branch_skip bscu_branch_skip_chk chk (.clk(clk), .nrst(nrst), .req(req), .op(op), .bit_sel(bit_sel),
    .offset(offset), .pc(pc), .next_two_word(next_two_word), .reg_data(reg_data), .io_data(io_data),
    .flags(flags), .busy_r(busy_r), .done_r(done_r), .taken_r(taken_r), .pc_next_r(pc_next_r),
    .cycles_r(cycles_r), .flag_write_r(flag_write_r));
`default_nettype wire

// *** bscu_branch_skip_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module bscu_branch_skip_tb
    import bscu_pkg::*;
;
    logic clk, nrst, req, next_two_word, busy_r, done_r, taken_r, flag_write_r;
    bscu_op_e op;
    logic [2:0] bit_sel;
    logic [6:0] offset;
    bscu_pc_t pc, pc_next_r;
    bscu_byte_t reg_data, io_data, flags;
    bscu_cyc_t cycles_r;
    int err_total = 0;
    int compares = 0;
    int ticks = 0;
    // Flag bytes that make each branch taken; index is the op code
    bscu_byte_t hit [21] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'hDF, 8'h02, 8'hFD, 8'h01, 8'hFE, 8'hFE,
        8'h01, 8'h04, 8'hFB, 8'h0C, 8'h04, 8'h20, 8'hDF, 8'h40, 8'hBF, 8'h08};

    bscu_branch_skip DUT (.clk(clk), .nrst(nrst), .req(req), .op(op), .bit_sel(bit_sel), .offset(offset),
        .pc(pc), .next_two_word(next_two_word), .reg_data(reg_data), .io_data(io_data), .flags(flags),
        .busy_r(busy_r), .done_r(done_r), .taken_r(taken_r), .pc_next_r(pc_next_r), .cycles_r(cycles_r),
        .flag_write_r(flag_write_r));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic close_out();
        if (err_total == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        ticks++;
        if (ticks == 3000) begin
            err_total++;
            close_out();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic drive(input bscu_op_e o, input logic [2:0] b, input logic [6:0] k, input bscu_pc_t p,
        input logic two, input bscu_byte_t rd, input bscu_byte_t iod, input bscu_byte_t fl);
        req <= 1'b1;
        op <= o;
        bit_sel <= b;
        offset <= k;
        pc <= p;
        next_two_word <= two;
        reg_data <= rd;
        io_data <= iod;
        flags <= fl;
    endtask

    // Done is awaited under a bound, and the edges counted must equal the cycle figure
    task automatic issue(input bscu_op_e o, input logic [2:0] b, input logic [6:0] k, input bscu_pc_t p,
        input logic two, input bscu_byte_t rd, input bscu_byte_t iod, input bscu_byte_t fl,
        input logic et, input bscu_pc_t ep, input bscu_cyc_t ec);
        int n;
        @(posedge clk);
        drive(o, b, k, p, two, rd, iod, fl);
        @(posedge clk);
        req <= 1'b0;
        n = 1;
        #1;
        check(taken_r, et);
        check(pc_next_r, ep);
        check(cycles_r, ec);
        while (done_r !== 1'b1 && n < 5) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n), ec);
        check(flag_write_r, 1'b0);
    endtask

    task automatic skips();
        issue(op_skip_reg_bit_one, 3'h3, 7'h00, 16'h0040, 1'b1, 8'h08, 8'h00, 8'h00, 1'b1, 16'h0043, 2'h3);
        issue(op_skip_reg_bit_one, 3'h3, 7'h00, 16'h0040, 1'b1, 8'hF7, 8'hFF, 8'h00, 1'b0, 16'h0041, 2'h1);
        issue(op_skip_io_bit_zero, 3'h0, 7'h00, 16'h0050, 1'b0, 8'h01, 8'hFE, 8'h00, 1'b1, 16'h0052, 2'h2);
        issue(op_skip_io_bit_zero, 3'h0, 7'h00, 16'h0050, 1'b0, 8'h00, 8'h01, 8'h00, 1'b0, 16'h0051, 2'h1);
        issue(op_skip_io_bit_one, 3'h7, 7'h00, 16'h0060, 1'b0, 8'h00, 8'h80, 8'h00, 1'b1, 16'h0062, 2'h2);
        issue(op_skip_io_bit_one, 3'h7, 7'h00, 16'h0060, 1'b1, 8'h80, 8'h7F, 8'h00, 1'b0, 16'h0061, 2'h1);
    endtask

    // Signed pair is missed by flipping N only, since inverting both keeps N xor V
    task automatic branches();
        bscu_op_e o;
        bscu_byte_t miss;
        for (int i = 4; i <= 20; i++) begin
            o = bscu_op_e'(i);
            miss = (o == op_branch_signed_ge || o == op_branch_signed_lt) ? hit[i] ^ 8'h04 : ~hit[i];
            issue(o, 3'h5, 7'h05, 16'h0100, 1'b0, 8'h00, 8'h00, hit[i], 1'b1, 16'h0106, 2'h2);
            issue(o, 3'h5, 7'h05, 16'h0100, 1'b0, 8'h00, 8'h00, miss, 1'b0, 16'h0101, 2'h1);
        end
    endtask

    task automatic offsets();
        issue(op_branch_carry_one, 3'h0, 7'h40, 16'h0010, 1'b0, 8'h00, 8'h00, 8'h01, 1'b1, 16'hFFD1, 2'h2);
        issue(op_branch_carry_one, 3'h0, 7'h3F, 16'hFFF0, 1'b0, 8'h00, 8'h00, 8'h01, 1'b1, 16'h0030, 2'h2);
    endtask

    task automatic refusals();
        @(posedge clk);
        drive(op_skip_io_bit_one, 3'h7, 7'h00, 16'h0200, 1'b1, 8'h00, 8'h80, 8'h00);
        @(posedge clk);
        drive(op_branch_equal, 3'h0, 7'h10, 16'h0300, 1'b0, 8'h00, 8'h00, 8'h02);
        @(posedge clk);
        req <= 1'b0;
        #1;
        check(pc_next_r, 16'h0203);
        check(done_r, 1'b0);
        @(posedge clk);
        drive(bscu_op_e'(5'h1F), 3'h0, 7'h10, 16'h0400, 1'b0, 8'h00, 8'h00, 8'hFF);
        #1;
        check(done_r, 1'b1);
        @(posedge clk);
        req <= 1'b0;
        #1;
        check(done_r, 1'b0);
        @(posedge clk);
        #1;
        check(done_r, 1'b0);
        check(pc_next_r, 16'h0203);
    endtask

    task automatic back_to_back();
        @(posedge clk);
        drive(op_branch_equal, 3'h0, 7'h00, 16'h0010, 1'b0, 8'h00, 8'h00, 8'h00);
        @(posedge clk);
        drive(op_branch_not_equal, 3'h0, 7'h00, 16'h0020, 1'b0, 8'h00, 8'h00, 8'h00);
        #1;
        check(pc_next_r, 16'h0011);
        check(done_r, 1'b1);
        @(posedge clk);
        req <= 1'b0;
        #1;
        check(pc_next_r, 16'h0021);
        check(busy_r, 1'b1);
        repeat (2) @(posedge clk);
    endtask

    initial begin
        nrst = 1'b0;
        req = 1'b0;
        op = op_none;
        bit_sel = 3'h0;
        offset = 7'h00;
        pc = 16'h0000;
        next_two_word = 1'b0;
        reg_data = 8'h00;
        io_data = 8'h00;
        flags = 8'h00;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        skips();
        branches();
        offsets();
        refusals();
        back_to_back();
        close_out();
    end
endmodule
`default_nettype wire
